// file: core/plc_immediate_io.sv
// Execution unit for the live input/output instructions of the controller.
// Assumes the sequencer presents one instruction per valid cycle and pulses
// scanStart once at the head of every scan; the image register lives elsewhere.
`timescale 1ns/100ps

// Functional notes
// - Live start contact begins rung with sampled input point state.
// - Live inverted start contact begins rung with inverted sampled input.
// - Live reads and writes never touch the input/output image register.
// - Live parallel contact ORs sampled input into rung logic.
// - Live inverted parallel contact ORs inverted sampled input into rung.
// - Live series contact ANDs sampled input into rung logic.
// - Live inverted series contact ANDs inverted sampled input into rung.
// - Several ORed live coils on one output: on if any rung on.
// - True rung sets output point range directly on modules.
// - True rung clears output point range directly on modules.
// - Set or cleared outputs hold until the opposite instruction acts.
// - Word load takes sixteen live input bits at addressed word.
// - Bit load takes 1 to 32 live input bits from start point.
// - Bit load zeroes accumulator bits beyond the bit count.
// - Word write drives sixteen accumulator bits to addressed output word.
// - Bit write drives 1 to 32 low accumulator bits from start point.
module plc_immediate_io
   import immio_pkg::*;
#(
   parameter int NPTS = NUM_POINTS
) (
   input  wire logic                clk,
   input  wire logic                resetn,
   input  wire logic                scanStart,
   input  wire logic                instrValid,
   input  wire imm_op_e             instrOp,
   input  wire logic [POINT_W-1:0]  operandPoint,
   input  wire logic [POINT_W-1:0]  rangeLast,
   input  wire logic [COUNT_W-1:0]  bitCount,
   input  wire logic [15:0]         wordAddr,
   input  wire logic [NPTS-1:0]     liveInputs,
   output      logic [NPTS-1:0]     outputPoints,
   output      logic [ACC_BITS-1:0] accumulator,
   output      logic                rungLogic,
   output      logic                execDone,
   output      logic                opError
);

   // ==========================================================================
   // Held state.
   logic [NPTS-1:0]     outputs_r;
   logic [NPTS-1:0]     outputs_nxt;
   logic [NPTS-1:0]     coilSeen_r;
   logic [NPTS-1:0]     coilSeen_nxt;
   logic [ACC_BITS-1:0] acc_r;
   logic [ACC_BITS-1:0] acc_nxt;
   logic                rung_r;
   logic                rung_nxt;
   logic                done_r;
   logic                err_r;
   logic                err_nxt;

   // ==========================================================================
   // Opcode classes.
   logic isStart;
   logic isParallel;
   logic isSeries;
   logic isInverted;
   logic isContact;
   logic isCoil;
   logic isSetClr;
   logic isWordOp;
   logic isFmtOp;
   logic isLoad;
   logic isWrite;

   assign isStart    = (instrOp == OP_START) || (instrOp == OP_START_INV);
   assign isParallel = (instrOp == OP_PARALLEL) || (instrOp == OP_PARALLEL_INV);
   assign isSeries   = (instrOp == OP_SERIES) || (instrOp == OP_SERIES_INV);
   assign isInverted = (instrOp == OP_START_INV) || (instrOp == OP_PARALLEL_INV)
                     || (instrOp == OP_SERIES_INV);
   assign isContact  = isStart || isParallel || isSeries;
   assign isCoil     = (instrOp == OP_CORED_COIL);
   assign isSetClr   = (instrOp == OP_SET_OUTPUTS) || (instrOp == OP_CLEAR_OUTPUTS);
   assign isWordOp   = (instrOp == OP_LOAD_WORD) || (instrOp == OP_WORD_WRITE);
   assign isFmtOp    = (instrOp == OP_LOAD_BITS) || (instrOp == OP_WRITE_BITS);
   assign isLoad     = (instrOp == OP_LOAD_WORD) || (instrOp == OP_LOAD_BITS);
   assign isWrite    = (instrOp == OP_WORD_WRITE) || (instrOp == OP_WRITE_BITS);

   // ==========================================================================
   // Operand checks. A bad operand is refused and flagged, with no side effect,
   // so that a miscoded program cannot disturb points it never named.
   logic [15:0]          wordOffset;
   logic                 wordOk;
   logic                 fmtOk;
   logic                 rangeOk;
   logic [POINT_W:0]     fmtEnd;
   logic                 operandOk;

   assign wordOffset = wordAddr - WORD_ADDR_FIRST;
   assign wordOk     = (wordAddr >= WORD_ADDR_FIRST) && (wordAddr <= WORD_ADDR_LAST);
   assign fmtEnd     = {1'b0, operandPoint} + (POINT_W + 1)'(bitCount);
   assign fmtOk      = (bitCount >= FMT_MIN_BITS) && (bitCount <= FMT_MAX_BITS)
                     && (fmtEnd <= (POINT_W + 1)'(NPTS));
   assign rangeOk    = (rangeLast >= operandPoint);
   assign operandOk  = isWordOp ? wordOk
                     : isFmtOp  ? fmtOk
                     : isSetClr ? rangeOk
                     : (instrOp != OP_NONE);

   // ==========================================================================
   // Live point sampling. The input pins are read in the executing cycle and
   // nothing is copied into any image store.
   logic                liveBit;
   logic                contactVal;
   logic [NPTS-1:0]     ptSel;

   assign liveBit    = liveInputs[operandPoint];
   assign contactVal = liveBit ^ isInverted;
   assign ptSel      = NPTS'(1) << operandPoint;

   // ==========================================================================
   // Run selection shared by word and formatted transfers.
   logic [POINT_W-1:0]  runStart;
   logic [COUNT_W-1:0]  runCount;
   logic [ACC_BITS-1:0] gathered;
   logic [NPTS-1:0]     scattered;
   logic [ACC_BITS-1:0] fmtMaskW;

   assign runStart = isWordOp ? {wordOffset[WORD_IDX_W-1:0], 4'h0} : operandPoint;
   assign runCount = isWordOp ? WORD_COUNT : bitCount;
   assign fmtMaskW = fmtMask(runCount);

   live_bit_gather #(
      .NPTS       (NPTS)
   ) u_gather (
      .points     (liveInputs),
      .startPoint (runStart),
      .bitCount   (runCount),
      .value      (gathered)
   );

   live_bit_scatter #(
      .NPTS       (NPTS)
   ) u_scatter (
      .current    (outputs_r),
      .startPoint (runStart),
      .bitCount   (runCount),
      .data       (acc_r),
      .updated    (scattered)
   );

   // ==========================================================================
   // Inclusive range mask for set and clear, first point to last point.
   logic [NPTS-1:0]     rangeMask;
   logic [POINT_W:0]    rangeTop;

   assign rangeTop  = {1'b0, rangeLast} + (POINT_W + 1)'(1);
   assign rangeMask = ((NPTS'(1) << rangeTop) - NPTS'(1)) & ~(ptSel - NPTS'(1));

   // ==========================================================================
   // Next rung logic value.
   logic doExec;
   assign doExec   = instrValid && operandOk;
   assign rung_nxt = !(doExec && isContact) ? rung_r
                   : isStart    ? contactVal
                   : isParallel ? (rung_r | contactVal)
                   : (rung_r & contactVal);

   // ==========================================================================
   // Next output points. The first coil in a scan writes the rung value, later
   // ones OR into it, so an output is on if any of its rungs was on. Outputs
   // untouched by an instruction simply hold.
   logic [NPTS-1:0] coilNext;
   logic            coilBit;

   assign coilBit  = (coilSeen_r[operandPoint] && !scanStart && outputs_r[operandPoint])
                   | rung_r;
   assign coilNext = coilBit ? (outputs_r | ptSel) : (outputs_r & ~ptSel);

   assign outputs_nxt = !doExec ? outputs_r
                      : isCoil ? coilNext
                      : (instrOp == OP_SET_OUTPUTS) && rung_r ?
                          (outputs_r | rangeMask)
                      : (instrOp == OP_CLEAR_OUTPUTS) && rung_r ?
                          (outputs_r & ~rangeMask)
                      : isWrite && rung_r ? scattered
                      : outputs_r;

   // A scan start wipes the record of coils already driven this scan; a coil in
   // that same cycle is the first of the new scan, so its own mark is kept.
   assign coilSeen_nxt = scanStart ? ((doExec && isCoil) ? ptSel : '0)
                       : (doExec && isCoil) ? (coilSeen_r | ptSel)
                       : coilSeen_r;

   // ==========================================================================
   // Next accumulator. The gather already zeroes bits past the count.
   assign acc_nxt = (doExec && isLoad && rung_r) ? gathered
                  : acc_r;
   assign err_nxt = instrValid && !operandOk;

   // ==========================================================================
   // State registers. Every result lands at the edge that takes the
   // instruction, so the next instruction already sees it.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         outputs_r  <= '0;
         coilSeen_r <= '0;
         acc_r      <= ACC_RESET;
         rung_r     <= RUNG_RESET;
         done_r     <= 1'b0;
         err_r      <= 1'b0;
      end else begin
         outputs_r  <= outputs_nxt;
         coilSeen_r <= coilSeen_nxt;
         acc_r      <= acc_nxt;
         rung_r     <= rung_nxt;
         done_r     <= instrValid;
         err_r      <= err_nxt;
      end
   end

   // Outputs straight from flip-flops.
   assign outputPoints = outputs_r;
   assign accumulator  = acc_r;
   assign rungLogic    = rung_r;
   assign execDone     = done_r;
   assign opError      = err_r;

   // ==========================================================================
   // Checks on the execution behaviour.
   property p_start_live;
      @(posedge clk) disable iff (!resetn)
      (instrValid && instrOp == OP_START) |=> (rungLogic == $past(liveBit));
   endproperty
   a_start_live: assert property (p_start_live)
      else $error("Start contact did not take the live input state.");

   property p_start_inv;
      @(posedge clk) disable iff (!resetn)
      (instrValid && instrOp == OP_START_INV) |=> (rungLogic != $past(liveBit));
   endproperty
   a_start_inv: assert property (p_start_inv)
      else $error("Inverted start contact did not invert the live input.");

   property p_contact_no_side;
      @(posedge clk) disable iff (!resetn)
      (instrValid && isContact) |=> ($stable(outputPoints) && $stable(accumulator));
   endproperty
   a_contact_no_side: assert property (p_contact_no_side)
      else $error("Contact instruction disturbed outputs or accumulator.");

   property p_parallel;
      @(posedge clk) disable iff (!resetn)
      (instrValid && instrOp == OP_PARALLEL)
         |=> (rungLogic == ($past(rungLogic) | $past(liveBit)));
   endproperty
   a_parallel: assert property (p_parallel)
      else $error("Parallel contact did not OR the live input.");

   property p_series_inv;
      @(posedge clk) disable iff (!resetn)
      (instrValid && instrOp == OP_SERIES_INV)
         |=> (rungLogic == ($past(rungLogic) & !$past(liveBit)));
   endproperty
   a_series_inv: assert property (p_series_inv)
      else $error("Inverted series contact did not AND the inverted input.");

   property p_coil_on;
      @(posedge clk) disable iff (!resetn)
      (instrValid && isCoil && rungLogic) |=> ((outputPoints & $past(ptSel)) != '0);
   endproperty
   a_coil_on: assert property (p_coil_on)
      else $error("ORed coil with a true rung left its output off.");

   property p_set_range;
      @(posedge clk) disable iff (!resetn)
      (instrValid && instrOp == OP_SET_OUTPUTS && rungLogic && rangeOk)
         |=> ((outputPoints & $past(rangeMask)) == $past(rangeMask));
   endproperty
   a_set_range: assert property (p_set_range)
      else $error("Set did not turn on the whole output range.");

   property p_clear_range;
      @(posedge clk) disable iff (!resetn)
      (instrValid && instrOp == OP_CLEAR_OUTPUTS && rungLogic && rangeOk)
         |=> ((outputPoints & $past(rangeMask)) == '0);
   endproperty
   a_clear_range: assert property (p_clear_range)
      else $error("Clear did not turn off the whole output range.");

   property p_hold_idle;
      @(posedge clk) disable iff (!resetn)
      !instrValid |=> $stable(outputPoints) && $stable(accumulator);
   endproperty
   a_hold_idle: assert property (p_hold_idle)
      else $error("Outputs or accumulator changed with no instruction.");

   property p_load_word;
      @(posedge clk) disable iff (!resetn)
      (instrValid && instrOp == OP_LOAD_WORD && wordOk && rungLogic)
         |=> (accumulator == {16'h0000, $past(gathered[15:0])});
   endproperty
   a_load_word: assert property (p_load_word)
      else $error("Word load did not place the live input word.");

   property p_fmt_zero;
      @(posedge clk) disable iff (!resetn)
      (instrValid && instrOp == OP_LOAD_BITS && fmtOk && rungLogic)
         |=> ((accumulator & ~$past(fmtMaskW)) == '0);
   endproperty
   a_fmt_zero: assert property (p_fmt_zero)
      else $error("Bit load left accumulator bits set beyond the count.");

   property p_done;
      @(posedge clk) disable iff (!resetn)
      instrValid |=> execDone ##1 (execDone == $past(instrValid));
   endproperty
   a_done: assert property (p_done)
      else $error("Completion did not follow the instruction by one cycle.");

   property p_parallel_inv;
      @(posedge clk) disable iff (!resetn)
      (instrValid && instrOp == OP_PARALLEL_INV)
         |=> (rungLogic == ($past(rungLogic) | !$past(liveBit)));
   endproperty
   a_parallel_inv: assert property (p_parallel_inv)
      else $error("Inverted parallel contact did not OR the inverted input.");

   property p_series;
      @(posedge clk) disable iff (!resetn)
      (instrValid && instrOp == OP_SERIES)
         |=> (rungLogic == ($past(rungLogic) & $past(liveBit)));
   endproperty
   a_series: assert property (p_series)
      else $error("Series contact did not AND the live input.");

   property p_load_bits;
      @(posedge clk) disable iff (!resetn)
      (instrValid && instrOp == OP_LOAD_BITS && fmtOk && rungLogic)
         |=> (accumulator[0] == $past(liveBit));
   endproperty
   a_load_bits: assert property (p_load_bits)
      else $error("Bit load did not take the live start point into bit zero.");

   property p_word_write;
      @(posedge clk) disable iff (!resetn)
      (instrValid && instrOp == OP_WORD_WRITE && wordOk && rungLogic)
         |=> (16'(outputPoints >> {$past(wordAddr[WORD_IDX_W-1:0]), 4'h0})
              == $past(accumulator[15:0]));
   endproperty
   a_word_write: assert property (p_word_write)
      else $error("Word write did not drive the low accumulator word.");

endmodule : plc_immediate_io

// file: core/immio_pkg.sv
// Constants, opcodes and shared decode helpers for the live I/O instruction unit.
// Assumes one clock domain; every file of the unit imports this package whole.
package immio_pkg;

   // ==========================================================================
   // Sizes of the point space and of the accumulator.
   localparam int          NUM_POINTS      = 1024;     // Points 0 to 1777 octal.
   localparam int          POINT_W         = 10;
   localparam int          ACC_BITS        = 32;
   localparam int          WORD_BITS       = 16;
   localparam int          COUNT_W         = 6;
   localparam int          WORD_IDX_W      = 6;
   localparam logic [5:0]  FMT_MIN_BITS    = 6'h01;
   localparam logic [5:0]  FMT_MAX_BITS    = 6'h20;
   localparam logic [5:0]  WORD_COUNT      = 6'h10;

   // ==========================================================================
   // Word addresses of the local-base points, 40400 to 40477 octal.
   localparam logic [15:0] WORD_ADDR_FIRST = 16'h4100;
   localparam logic [15:0] WORD_ADDR_LAST  = 16'h413f;

   // ==========================================================================
   // Reset values of the held state.
   localparam logic [31:0] ACC_RESET       = 32'h0000_0000;
   localparam logic        RUNG_RESET      = 1'b0;

   // ==========================================================================
   // Instruction codes presented by the sequencer.
   typedef enum logic [3:0] {
      OP_NONE          = 4'h0,
      OP_START         = 4'h1,  // start_contact_live
      OP_START_INV     = 4'h2,  // start_contact_live_inverted
      OP_PARALLEL      = 4'h3,  // parallel_contact_live
      OP_PARALLEL_INV  = 4'h4,  // parallel_contact_live_inverted
      OP_SERIES        = 4'h5,  // series_contact_live
      OP_SERIES_INV    = 4'h6,  // series_contact_live_inverted
      OP_CORED_COIL    = 4'h7,  // ored_coil_or_word_write_live, coil form
      OP_WORD_WRITE    = 4'h8,  // ored_coil_or_word_write_live, word form
      OP_SET_OUTPUTS   = 4'h9,  // set_outputs_live
      OP_CLEAR_OUTPUTS = 4'ha,  // clear_outputs_live
      OP_LOAD_WORD     = 4'hb,  // load_input_word_live
      OP_LOAD_BITS     = 4'hc,  // load_input_bits_live
      OP_WRITE_BITS    = 4'hd   // write_output_bits_live
   } imm_op_e;

   // Low-order mask of n bits, n from 0 to 32.
   function automatic logic [31:0] fmtMask(input logic [5:0] n);
      fmtMask = (n >= FMT_MAX_BITS) ? 32'hffff_ffff : ((32'h1 << n) - 32'h1);
   endfunction : fmtMask

endpackage : immio_pkg

// file: core/live_bit_gather.sv
// Gathers a run of live input points into a right-justified accumulator value.
// Assumes the caller has checked that start and count fit the point space.
`timescale 1ns/100ps
module live_bit_gather
   import immio_pkg::*;
#(
   parameter int NPTS = NUM_POINTS
) (
   input  wire logic [NPTS-1:0]     points,
   input  wire logic [POINT_W-1:0]  startPoint,
   input  wire logic [COUNT_W-1:0]  bitCount,
   output      logic [ACC_BITS-1:0] value
);

   // ==========================================================================
   // Shift the run down and clear every bit beyond the count.
   logic [NPTS-1:0] shifted;
   assign shifted = points >> startPoint;
   assign value   = shifted[ACC_BITS-1:0] & fmtMask(bitCount);

endmodule : live_bit_gather

// file: core/live_bit_scatter.sv
// Replaces a run of output points with the low-order bits of a data word.
// Bits that would land beyond the last point are dropped by the shift.
`timescale 1ns/100ps
module live_bit_scatter
   import immio_pkg::*;
#(
   parameter int NPTS = NUM_POINTS
) (
   input  wire logic [NPTS-1:0]     current,
   input  wire logic [POINT_W-1:0]  startPoint,
   input  wire logic [COUNT_W-1:0]  bitCount,
   input  wire logic [ACC_BITS-1:0] data,
   output      logic [NPTS-1:0]     updated
);

   // ==========================================================================
   // Widen mask and data to the point space, then merge at the start point.
   logic [NPTS-1:0] runMask;
   logic [NPTS-1:0] runData;
   assign runMask = NPTS'(fmtMask(bitCount)) << startPoint;
   assign runData = NPTS'(data & fmtMask(bitCount)) << startPoint;
   assign updated = (current & ~runMask) | runData;

endmodule : live_bit_scatter

// file: dv/io_module_model.sv
// Behavioural model of the input and output modules on the local base.
// Assumes one clock; the bench hands new field states to the input terminals.
`timescale 1ns/100ps
module io_module_model
   import immio_pkg::*;
#(
   parameter int NPTS = NUM_POINTS
) (
   input  wire logic            clk,
   input  wire logic            resetn,
   input  wire logic            fieldLoad,
   input  wire logic [NPTS-1:0] fieldValue,
   input  wire logic [NPTS-1:0] outputPoints,
   output      logic [NPTS-1:0] liveInputs,
   output      logic [NPTS-1:0] loadState
);
   // ==========================================================================
   // Input terminals change only at a clock edge, so a point is never read mid-change.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         liveInputs <= '0;
      end else if (fieldLoad) begin
         liveInputs <= fieldValue;
      end
   end

   // Output terminals follow the unit's points with no delay of their own.
   assign loadState = outputPoints;
endmodule : io_module_model

// file: dv/plc_immediate_io_bench.sv
// Self-checking bench for the live input/output instruction unit.
// Assumes the unit and the module model are compiled first; one clock of 40 MHz.
`timescale 1ns/100ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_errors++; \
   $display("CHECK FAILED at %0t: got %h expected %h", $time, (a), (e)); end end
module plc_immediate_io_bench;
   import immio_pkg::*;
   localparam int            NP  = NUM_POINTS;
   localparam logic [NP-1:0] PAT = {32{32'h5a3c_9621}}; // Point 5 on, point 6 off.
   logic                clk          = 1'b0;
   logic                resetn       = 1'b0;
   logic                scanStart    = 1'b0;
   logic                instrValid   = 1'b0;
   imm_op_e             instrOp      = OP_NONE;
   logic [POINT_W-1:0]  operandPoint = '0;
   logic [POINT_W-1:0]  rangeLast    = '0;
   logic [COUNT_W-1:0]  bitCount     = '0;
   logic [15:0]         wordAddr     = 16'h4100;
   logic                fieldLoad    = 1'b0;
   logic [NP-1:0]       fieldValue   = '0;
   logic [NP-1:0]       liveInputs;
   logic [NP-1:0]       outputPoints;
   logic [NP-1:0]       loadState;
   logic [ACC_BITS-1:0] accumulator;
   logic                rungLogic;
   logic                execDone;
   logic                opError;
   logic                lastErr;
   int                  n_errors     = 0;
   int                  total_checks = 0;
   int                  cycleCount   = 0;

   // ==========================================================================
   // Unit and far-side model.
   plc_immediate_io #(.NPTS(NP)) uut (.clk(clk), .resetn(resetn), .scanStart(scanStart),
      .instrValid(instrValid), .instrOp(instrOp), .operandPoint(operandPoint),
      .rangeLast(rangeLast), .bitCount(bitCount), .wordAddr(wordAddr),
      .liveInputs(liveInputs), .outputPoints(outputPoints), .accumulator(accumulator),
      .rungLogic(rungLogic), .execDone(execDone), .opError(opError));
   io_module_model #(.NPTS(NP)) field (.clk(clk), .resetn(resetn), .fieldLoad(fieldLoad),
      .fieldValue(fieldValue), .outputPoints(outputPoints), .liveInputs(liveInputs),
      .loadState(loadState));

   // Clock and a watchdog; the whole run needs under a hundred cycles.
   initial begin
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycleCount++;
      if (cycleCount == 3000) begin
         n_errors++;
         results();
      end
   end

   // ==========================================================================
   // Shared drivers. One instruction per call, with one idle edge before it.
   task automatic exec(input imm_op_e op, input logic [9:0] pt = 10'h000,
                       input logic [9:0] last = 10'h000, input logic [5:0] cnt = 6'h00,
                       input logic [15:0] wa = 16'h4100);
      @(posedge clk);
      instrValid   <= 1'b1;
      instrOp      <= op;
      operandPoint <= pt;
      rangeLast    <= last;
      bitCount     <= cnt;
      wordAddr     <= wa;
      @(posedge clk);
      instrValid   <= 1'b0;
      #1;
      `CHK(execDone, 1'b1)
      lastErr = opError;
   endtask : exec

   task automatic setField(input logic [NP-1:0] v);
      @(posedge clk);
      fieldValue <= v;
      fieldLoad  <= 1'b1;
      @(posedge clk);
      fieldLoad  <= 1'b0;
   endtask : setField

   task automatic newScan();
      @(posedge clk);
      scanStart <= 1'b1;
      @(posedge clk);
      scanStart <= 1'b0;
   endtask : newScan

   // ==========================================================================
   // Contacts: each step's result differs from what a neighbouring code would give.
   task automatic contactTest();
      imm_op_e             ops [6] = '{OP_START_INV, OP_PARALLEL, OP_SERIES,
                                       OP_PARALLEL_INV, OP_SERIES_INV, OP_START};
      logic [9:0]          pts [6] = '{10'd5, 10'd5, 10'd6, 10'd6, 10'd5, 10'd5};
      logic                exp [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
      logic [NP-1:0]       outSnap;
      logic [ACC_BITS-1:0] accSnap;
      outSnap = outputPoints;
      accSnap = accumulator;
      for (int i = 0; i < 6; i++) begin
         exec(ops[i], pts[i]);
         `CHK(rungLogic, exp[i])
      end
      `CHK({outputPoints, accumulator}, {outSnap, accSnap})
      setField(~PAT);
      exec(OP_START, 10'd5);
      `CHK(rungLogic, 1'b0)
      setField(PAT);
   endtask : contactTest

   // ORed coil: a later off rung in the same scan must not turn the point off.
   task automatic coilTest();
      newScan();
      exec(OP_START, 10'd5);
      exec(OP_CORED_COIL, 10'd100);
      `CHK(loadState[100], 1'b1)
      exec(OP_START, 10'd6);
      exec(OP_CORED_COIL, 10'd100);
      `CHK(loadState[100], 1'b1)
      newScan();
      exec(OP_CORED_COIL, 10'd100);
      `CHK(loadState[100], 1'b0)
   endtask : coilTest

   // Set and clear a range; the neighbours on each side stay off.
   task automatic setClearTest();
      exec(OP_START, 10'd5);
      exec(OP_SET_OUTPUTS, 10'd200, 10'd215);
      `CHK(outputPoints[216:199], {1'b0, 16'hffff, 1'b0})
      exec(OP_START, 10'd6);
      exec(OP_CLEAR_OUTPUTS, 10'd200, 10'd215);
      `CHK(outputPoints[215:200], 16'hffff)
      exec(OP_START, 10'd5);
      exec(OP_CLEAR_OUTPUTS, 10'd200, 10'd215);
      `CHK(outputPoints[216:199], 18'h00000)
   endtask : setClearTest

   // Word and formatted transfers, including the widest and narrowest counts.
   task automatic transferTest();
      exec(OP_LOAD_BITS, 10'd8, 10'd0, 6'd32);
      `CHK({lastErr, accumulator}, {1'b0, PAT[39:8]})
      exec(OP_WRITE_BITS, 10'd300, 10'd0, 6'd5);
      `CHK(outputPoints[305:300], {1'b0, PAT[12:8]})
      exec(OP_WORD_WRITE, 10'd0, 10'd0, 6'd0, 16'h413f);
      `CHK(outputPoints[1023:1008], PAT[23:8])
      exec(OP_LOAD_BITS, 10'd8, 10'd0, 6'd1);
      `CHK(accumulator, {31'h0, PAT[8]})
      exec(OP_LOAD_WORD, 10'd0, 10'd0, 6'd0, 16'h4101);
      `CHK(accumulator, {16'h0, PAT[31:16]})
   endtask : transferTest

   // Back to back: the write in the next cycle must see the freshly loaded value.
   task automatic backToBackTest();
      @(posedge clk);
      instrValid   <= 1'b1;
      instrOp      <= OP_LOAD_BITS;
      operandPoint <= 10'd40;
      bitCount     <= 6'd8;
      @(posedge clk);
      instrOp      <= OP_WRITE_BITS;
      operandPoint <= 10'd400;
      @(posedge clk);
      instrValid   <= 1'b0;
      @(posedge clk);
      #1;
      `CHK(outputPoints[407:400], PAT[47:40])
   endtask : backToBackTest

   // Out-of-range counts and addresses are refused and leave the accumulator alone.
   task automatic refuseTest();
      logic [ACC_BITS-1:0] accSnap;
      accSnap = accumulator;
      exec(OP_LOAD_BITS, 10'd8, 10'd0, 6'd0);
      `CHK({lastErr, accumulator}, {1'b1, accSnap})
      exec(OP_LOAD_BITS, 10'd8, 10'd0, 6'd33);
      `CHK({lastErr, accumulator}, {1'b1, accSnap})
      exec(OP_LOAD_WORD, 10'd0, 10'd0, 6'd0, 16'h4140);
      `CHK({lastErr, accumulator}, {1'b1, accSnap})
      exec(OP_NONE);
      `CHK({lastErr, accumulator}, {1'b1, accSnap})
      exec(OP_SET_OUTPUTS, 10'd20, 10'd10);
      `CHK(lastErr, 1'b1)
      exec(OP_WRITE_BITS, 10'd1000, 10'd0, 6'd32);
      `CHK({lastErr, outputPoints[1023:1008]}, {1'b1, PAT[23:8]})
   endtask : refuseTest

   task automatic results();
      $display("Comparisons: %0d, mismatches: %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : results

   // ==========================================================================
   // Main sequence.
   initial begin
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      setField(PAT);
      contactTest();
      coilTest();
      setClearTest();
      transferTest();
      backToBackTest();
      refuseTest();
      results();
   end
endmodule : plc_immediate_io_bench
